//--- design/pescr_regs.sv
// event status, general configuration and receive error counter registers on apb
// How it works
// R01: status bit sets if its event happened since the last status read.
// R02: status capture ignores interrupt enables; enables only gate the pin.
// R03: bits 15..10 latch high on negotiation/speed/duplex/page/done/link events; clear on read.
// R04: bit 8 flag_a and bit 7 converter fifo fault latch high, clear on read.
// R05: bits 6,5,4 latch crossover, downshift, sleep change; clear on read.
// R06: bit 0 latches jabber detection, clears on read.
// R07: bits 9,3,2,1 are read-only live status indications.
// R08: config bit 15 enables powered-device detection; resets to zero.
// R09: config bit 14 suppresses serial-side transmit error indication; resets zero.
// R10: config bit 13 selects interrupt pin level, 0 high, 1 low; resets one.
// R11: writing one to bit 12 issues one soft reset pulse; bit self-clears.
// R12: bits 11..10 give failed attempts before downshift: 1,2,4,8; reset code 2.
// R13: config bit 9 enables downshift; resets disabled.
// R14: bit 8 enhanced downshift when no energy on pairs c and d; resets one.
// R15: config bit 7 enables serial-side auto-negotiation; resets one.
// R16: bit 6 allows downshift to 10 Mb/s after 1G and 100M fail.
// R17: bits 5..4 pick 1g transmit clock: 2.5 MHz, 25 MHz, or off.
// R18: config bit 3 allows collision indication in full duplex; resets zero.
// R19: config bit 2 enables automatic legacy scrambler choice as 1G leader.
// R20: bits 1 and 0 enable semi-cross in 1G leader and follower; reset one.
// R21: receive error counter is 16 bits, resets zero, write-one clears bits.
// R22: counter adds one per receive symbol error and saturates at maximum.
// R23: interrupt pin is active when any enabled latched status bit is set; live bits 9,3,2,1 never drive it.
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
module pescr_regs (
   input wire logic core_clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pescr_pkg::ADDR_W-1:0] paddr,
   input wire logic [pescr_pkg::DATA_W-1:0] pwdata,
   output logic [pescr_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // one-cycle event pulses from the core, same clock
   input wire logic negotiation_error_evt,
   input wire logic speed_changed_evt,
   input wire logic duplex_changed_evt,
   input wire logic page_received_evt,
   input wire logic negotiation_done_evt,
   input wire logic link_changed_evt,
   input wire logic flag_a_evt,
   input wire logic converter_fifo_fault_evt,
   input wire logic crossover_changed_evt,
   input wire logic downshift_event_evt,
   input wire logic sleep_changed_evt,
   input wire logic jabber_evt,
   // live status levels, same clock
   input wire logic energy_efficient_error_flag,
   input wire logic wake_packet_flag,
   input wire logic mac_buffer_fault_flag,
   input wire logic polarity_changed_flag,
   input wire logic rx_symbol_error,
   // interrupt pin and configuration outputs
   output logic int_pin,
   output logic powered_device_detect_enable,
   output logic serial_tx_error_suppress,
   output logic serial_soft_reset_pulse,
   output logic [1:0] downshift_attempt_count,
   output logic [3:0] downshift_attempts,
   output logic downshift_enable,
   output logic downshift_enhanced_enable,
   output logic serial_side_negotiation_enable,
   output logic downshift_to_ten_enable,
   output logic [1:0] tx_clock_select,
   output logic tx_clock_off,
   output logic collision_in_full_duplex_enable,
   output logic legacy_scrambler_auto_enable,
   output logic leader_semi_cross_enable,
   output logic follower_semi_cross_enable
);
   typedef struct packed {
      logic [15:0] status;
      logic [15:0] cfg;
      logic [15:0] ien;
      logic [15:0] rx_cnt;
      logic [3:0] attempts;
      logic int_pin;
      logic soft_rst;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } pescr_state_t;

   pescr_state_t s_q;
   pescr_state_t s_d;

   logic [15:0] evt_vec;
   logic [15:0] ro_vec;
   logic [15:0] status_view;
   logic [15:0] rdval;
   logic [15:0] wval;
   logic [15:0] cnt_base;
   logic access;
   logic done;
   logic wr;
   logic rd;
   logic mapped;

   // gather event pulses into their bit positions
   always_comb begin
      evt_vec = '0;
      evt_vec[pescr_pkg::EVT_NEG_ERR] = negotiation_error_evt; // R03
      evt_vec[pescr_pkg::EVT_SPEED] = speed_changed_evt; // R03
      evt_vec[pescr_pkg::EVT_DUPLEX] = duplex_changed_evt; // R03
      evt_vec[pescr_pkg::EVT_PAGE] = page_received_evt; // R03
      evt_vec[pescr_pkg::EVT_NEG_DONE] = negotiation_done_evt; // R03
      evt_vec[pescr_pkg::EVT_LINK] = link_changed_evt; // R03
      evt_vec[pescr_pkg::EVT_FALSE_CARR] = flag_a_evt; // R04
      evt_vec[pescr_pkg::EVT_CONV_FIFO] = converter_fifo_fault_evt; // R04
      evt_vec[pescr_pkg::EVT_XOVER] = crossover_changed_evt; // R05
      evt_vec[pescr_pkg::EVT_DOWNSHIFT] = downshift_event_evt; // R05
      evt_vec[pescr_pkg::EVT_SLEEP] = sleep_changed_evt; // R05
      evt_vec[pescr_pkg::EVT_JABBER] = jabber_evt; // R06
      ro_vec = '0;
      ro_vec[pescr_pkg::EVT_EEE_ERR] = energy_efficient_error_flag; // R07
      ro_vec[pescr_pkg::EVT_WAKE] = wake_packet_flag; // R07
      ro_vec[pescr_pkg::EVT_MAC_BUF] = mac_buffer_fault_flag; // R07
      ro_vec[pescr_pkg::EVT_POLARITY] = polarity_changed_flag; // R07
   end

   // bus decode; the answer comes one cycle into the access phase
   assign access = psel & penable;
   assign done = access & s_q.pready;
   assign wr = done & pwrite;
   assign rd = done & ~pwrite;
   assign wval = pwdata[15:0];
   assign status_view = (s_q.status & pescr_pkg::EVT_RC_MASK) | (ro_vec & pescr_pkg::EVT_RO_MASK);

   // read mux; unmapped or misaligned addresses read zero and flag an error
   always_comb begin
      mapped = 1'b1;
      rdval = '0;
      case (paddr)
         pescr_pkg::ADDR_IRQ_ENABLE: begin
            rdval = s_q.ien;
         end
         pescr_pkg::ADDR_EVENT_STATUS: begin
            rdval = status_view; // R07
         end
         pescr_pkg::ADDR_GEN_CONFIG_TWO: begin
            rdval = s_q.cfg; // soft reset bit always reads back zero
         end
         pescr_pkg::ADDR_RX_ERR_COUNT: begin
            rdval = s_q.rx_cnt;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // next state of the whole bank
   always_comb begin
      s_d = s_q;

      // handshake: pready rises after one access cycle, drops after completion
      s_d.pready = access & ~s_q.pready;
      s_d.pslverr = access & ~s_q.pready & ~mapped;
      if (access & ~s_q.pready) begin
         s_d.prdata = {16'h0000, rdval};
      end

      // a read clears only the bits it reported, so events after the sample survive
      if (rd && paddr == pescr_pkg::ADDR_EVENT_STATUS) begin
         s_d.status = s_q.status & ~s_q.prdata[pescr_pkg::REG_W-1:0]; // R01
      end
      s_d.status = (s_d.status | evt_vec) & pescr_pkg::EVT_RC_MASK; // R01 R02

      // interrupt enables, own register
      if (wr && paddr == pescr_pkg::ADDR_IRQ_ENABLE) begin
         s_d.ien = wval;
      end

      // configuration word; soft reset bit is never stored
      s_d.soft_rst = 1'b0;
      if (wr && paddr == pescr_pkg::ADDR_GEN_CONFIG_TWO) begin
         s_d.cfg = wval; // R08 R09 R10 R13 R14 R15 R16 R18 R19 R20
         s_d.cfg[pescr_pkg::CFG_SOFT_RST] = 1'b0; // R11
         s_d.soft_rst = wval[pescr_pkg::CFG_SOFT_RST]; // R11
      end

      // attempt count decode: code n gives 2**n attempts
      s_d.attempts = pescr_pkg::ATTEMPT_ONE
         << s_d.cfg[pescr_pkg::CFG_ATTEMPT_HI:pescr_pkg::CFG_ATTEMPT_LO]; // R12

      // counter: write-one clear first, then a new error still counts
      cnt_base = s_q.rx_cnt;
      if (wr && paddr == pescr_pkg::ADDR_RX_ERR_COUNT) begin
         cnt_base = s_q.rx_cnt & ~wval; // R21
      end
      if (rx_symbol_error && cnt_base != pescr_pkg::RX_ERR_MAX) begin
         cnt_base = cnt_base + 16'h0001; // R22
      end
      s_d.rx_cnt = cnt_base;

      // pin level follows next status so it has no extra lag; xor applies polarity
      s_d.int_pin = (|(s_d.status & s_d.ien)) ^ s_d.cfg[pescr_pkg::CFG_IRQ_POL]; // R23 R10
   end

   // single state register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q.status <= pescr_pkg::RST_EVENT_STATUS;
         s_q.cfg <= pescr_pkg::RST_GEN_CONFIG_TWO;
         s_q.ien <= pescr_pkg::RST_IRQ_ENABLE;
         s_q.rx_cnt <= pescr_pkg::RST_RX_ERR_COUNT;
         s_q.attempts <= pescr_pkg::RST_ATTEMPTS;
         s_q.int_pin <= 1'b1; // inactive for the active-low reset polarity
         s_q.soft_rst <= 1'b0;
         s_q.pready <= 1'b0;
         s_q.pslverr <= 1'b0;
         s_q.prdata <= 32'h0000_0000;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state flops
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign int_pin = s_q.int_pin;
   assign serial_soft_reset_pulse = s_q.soft_rst; // R11
   assign powered_device_detect_enable = s_q.cfg[pescr_pkg::CFG_PD_DETECT]; // R08
   assign serial_tx_error_suppress = s_q.cfg[pescr_pkg::CFG_TX_ERR_SUP]; // R09
   assign downshift_attempt_count =
      s_q.cfg[pescr_pkg::CFG_ATTEMPT_HI:pescr_pkg::CFG_ATTEMPT_LO]; // R12
   assign downshift_attempts = s_q.attempts;
   assign downshift_enable = s_q.cfg[pescr_pkg::CFG_DS_EN]; // R13
   assign downshift_enhanced_enable = s_q.cfg[pescr_pkg::CFG_DS_ENH]; // R14
   assign serial_side_negotiation_enable = s_q.cfg[pescr_pkg::CFG_SER_NEG]; // R15
   assign downshift_to_ten_enable = s_q.cfg[pescr_pkg::CFG_DS_TEN]; // R16
   assign tx_clock_select = s_q.cfg[pescr_pkg::CFG_TXCLK_HI:pescr_pkg::CFG_TXCLK_LO]; // R17
   // codes 2 and 3 both stop the clock; only the high bit is needed
   assign tx_clock_off = s_q.cfg[pescr_pkg::CFG_TXCLK_HI]; // R17
   assign collision_in_full_duplex_enable = s_q.cfg[pescr_pkg::CFG_COL_FD]; // R18
   assign legacy_scrambler_auto_enable = s_q.cfg[pescr_pkg::CFG_LEGACY]; // R19
   assign leader_semi_cross_enable = s_q.cfg[pescr_pkg::CFG_LDR_SEMI]; // R20
   assign follower_semi_cross_enable = s_q.cfg[pescr_pkg::CFG_FLW_SEMI]; // R20
endmodule

//--- include/pescr_pkg.sv
// constants and field layout of the event status / configuration register bank
package pescr_pkg;
   // register indices and their byte addresses on the bus
   localparam logic [7:0] IDX_IRQ_ENABLE = 8'h12;
   localparam logic [7:0] IDX_EVENT_STATUS = 8'h13;
   localparam logic [7:0] IDX_GEN_CONFIG_TWO = 8'h14;
   localparam logic [7:0] IDX_RX_ERR_COUNT = 8'h15;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 8'(IDX_IRQ_ENABLE * 4);
   localparam logic [ADDR_W-1:0] ADDR_EVENT_STATUS = 8'(IDX_EVENT_STATUS * 4);
   localparam logic [ADDR_W-1:0] ADDR_GEN_CONFIG_TWO = 8'(IDX_GEN_CONFIG_TWO * 4);
   localparam logic [ADDR_W-1:0] ADDR_RX_ERR_COUNT = 8'(IDX_RX_ERR_COUNT * 4);

   // reset values and counter maximum
   localparam logic [15:0] RST_EVENT_STATUS = 16'h0000;
   localparam logic [15:0] RST_GEN_CONFIG_TWO = 16'h29c7;
   localparam logic [15:0] RST_RX_ERR_COUNT = 16'h0000;
   localparam logic [15:0] RST_IRQ_ENABLE = 16'h0000;
   localparam logic [15:0] RX_ERR_MAX = 16'hffff;
   localparam logic [3:0] RST_ATTEMPTS = 4'h4;

   // event status: latched-high clear-on-read bits and live read-only bits
   localparam logic [15:0] EVT_RC_MASK = 16'hfdf1;
   localparam logic [15:0] EVT_RO_MASK = 16'h020e;
   localparam int EVT_NEG_ERR = 15;
   localparam int EVT_SPEED = 14;
   localparam int EVT_DUPLEX = 13;
   localparam int EVT_PAGE = 12;
   localparam int EVT_NEG_DONE = 11;
   localparam int EVT_LINK = 10;
   localparam int EVT_EEE_ERR = 9;
   localparam int EVT_FALSE_CARR = 8;
   localparam int EVT_CONV_FIFO = 7;
   localparam int EVT_XOVER = 6;
   localparam int EVT_DOWNSHIFT = 5;
   localparam int EVT_SLEEP = 4;
   localparam int EVT_WAKE = 3;
   localparam int EVT_MAC_BUF = 2;
   localparam int EVT_POLARITY = 1;
   localparam int EVT_JABBER = 0;

   // general configuration two field positions
   localparam int CFG_PD_DETECT = 15;
   localparam int CFG_TX_ERR_SUP = 14;
   localparam int CFG_IRQ_POL = 13;
   localparam int CFG_SOFT_RST = 12;
   localparam int CFG_ATTEMPT_HI = 11;
   localparam int CFG_ATTEMPT_LO = 10;
   localparam int CFG_DS_EN = 9;
   localparam int CFG_DS_ENH = 8;
   localparam int CFG_SER_NEG = 7;
   localparam int CFG_DS_TEN = 6;
   localparam int CFG_TXCLK_HI = 5;
   localparam int CFG_TXCLK_LO = 4;
   localparam int CFG_COL_FD = 3;
   localparam int CFG_LEGACY = 2;
   localparam int CFG_LDR_SEMI = 1;
   localparam int CFG_FLW_SEMI = 0;

   // transmit clock select codes in 1g mode; attempt decode base
   localparam logic [1:0] TXCLK_2M5 = 2'h0;
   localparam logic [1:0] TXCLK_25M = 2'h1;
   localparam logic [3:0] ATTEMPT_ONE = 4'h1;
endpackage

//--- testbench/pescr_regs_assertions.sv
// concurrent checks on the register bank ports
`timescale 1ns/100ps
module pescr_regs_assertions (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pescr_pkg::ADDR_W-1:0] paddr,
   input wire logic [pescr_pkg::DATA_W-1:0] pwdata,
   input wire logic [pescr_pkg::DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic serial_soft_reset_pulse,
   input wire logic [1:0] downshift_attempt_count,
   input wire logic [3:0] downshift_attempts,
   input wire logic [1:0] tx_clock_select,
   input wire logic tx_clock_off
);
   logic cfg_wr;
   logic soft_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // completed write to the config word
   assign cfg_wr = psel && penable && pready && pwrite
      && paddr == pescr_pkg::ADDR_GEN_CONFIG_TWO;
   // remembers a soft reset request so the pulse can be traced to it
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         soft_q <= 1'b0;
      end else begin
         soft_q <= cfg_wr && pwdata[12];
      end
   end
   property p_wait; psel && penable && !pready |=> pready; endproperty
   a_wait: assert property (p_wait) else $error("pready not after one wait state");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("pready longer than one cycle");
   property p_err_zero; pslverr |-> pready && prdata == 32'h0; endproperty
   a_err_zero: assert property (p_err_zero) else $error("error response not clean");
   property p_upper; pready |-> prdata[31:16] == 16'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   property p_soft; cfg_wr && pwdata[12] |=> serial_soft_reset_pulse ##1 !serial_soft_reset_pulse;
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset pulse wrong");
   property p_soft_cause; serial_soft_reset_pulse |-> soft_q; endproperty
   a_soft_cause: assert property (p_soft_cause) else $error("stray soft reset pulse");
   property p_attempts; downshift_attempts == 4'h1 << downshift_attempt_count; endproperty
   a_attempts: assert property (p_attempts) else $error("attempt count decode");
   property p_txoff; tx_clock_off == tx_clock_select[1]; endproperty
   a_txoff: assert property (p_txoff) else $error("tx clock off decode");
   c_soft: cover property (serial_soft_reset_pulse);
   c_err: cover property (pslverr);
   c_wr: cover property (cfg_wr);
endmodule

//--- testbench/pescr_regs_bench.sv
// self-checking bench for the event status and configuration registers
`timescale 1ns/100ps
module pescr_regs_bench;
   localparam logic [7:0] A_ST = pescr_pkg::ADDR_EVENT_STATUS;
   localparam logic [7:0] A_CF = pescr_pkg::ADDR_GEN_CONFIG_TWO;
   localparam logic [7:0] A_RX = pescr_pkg::ADDR_RX_ERR_COUNT;
   localparam int POS [12] = '{15, 14, 13, 12, 11, 10, 8, 7, 6, 5, 4, 0};
   logic core_clk, rst, psel, penable, pwrite, pready, pslverr, int_pin, err, rx_symbol_error;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [11:0] evt_v;
   logic [3:0] ro_v, downshift_attempts;
   logic [1:0] downshift_attempt_count, tx_clock_select;
   logic negotiation_error_evt, speed_changed_evt, duplex_changed_evt, page_received_evt;
   logic negotiation_done_evt, link_changed_evt, flag_a_evt, converter_fifo_fault_evt;
   logic crossover_changed_evt, downshift_event_evt, sleep_changed_evt, jabber_evt;
   logic energy_efficient_error_flag, wake_packet_flag, mac_buffer_fault_flag;
   logic polarity_changed_flag, powered_device_detect_enable, serial_tx_error_suppress;
   logic serial_soft_reset_pulse, downshift_enable, downshift_enhanced_enable, tx_clock_off;
   logic serial_side_negotiation_enable, downshift_to_ten_enable;
   logic collision_in_full_duplex_enable, legacy_scrambler_auto_enable;
   logic leader_semi_cross_enable, follower_semi_cross_enable;
   int n_fail = 0;
   int n_checks = 0;
   // event pulses and live flags in status bit order
   assign {negotiation_error_evt, speed_changed_evt, duplex_changed_evt, page_received_evt,
      negotiation_done_evt, link_changed_evt, flag_a_evt, converter_fifo_fault_evt,
      crossover_changed_evt, downshift_event_evt, sleep_changed_evt, jabber_evt} = evt_v;
   assign {energy_efficient_error_flag, wake_packet_flag, mac_buffer_fault_flag,
      polarity_changed_flag} = ro_v;
   pescr_regs dut (
      .core_clk(core_clk),
      .rst(rst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .negotiation_error_evt(negotiation_error_evt),
      .speed_changed_evt(speed_changed_evt),
      .duplex_changed_evt(duplex_changed_evt),
      .page_received_evt(page_received_evt),
      .negotiation_done_evt(negotiation_done_evt),
      .link_changed_evt(link_changed_evt),
      .flag_a_evt(flag_a_evt),
      .converter_fifo_fault_evt(converter_fifo_fault_evt),
      .crossover_changed_evt(crossover_changed_evt),
      .downshift_event_evt(downshift_event_evt),
      .sleep_changed_evt(sleep_changed_evt),
      .jabber_evt(jabber_evt),
      .energy_efficient_error_flag(energy_efficient_error_flag),
      .wake_packet_flag(wake_packet_flag),
      .mac_buffer_fault_flag(mac_buffer_fault_flag),
      .polarity_changed_flag(polarity_changed_flag),
      .rx_symbol_error(rx_symbol_error),
      .int_pin(int_pin),
      .powered_device_detect_enable(powered_device_detect_enable),
      .serial_tx_error_suppress(serial_tx_error_suppress),
      .serial_soft_reset_pulse(serial_soft_reset_pulse),
      .downshift_attempt_count(downshift_attempt_count),
      .downshift_attempts(downshift_attempts),
      .downshift_enable(downshift_enable),
      .downshift_enhanced_enable(downshift_enhanced_enable),
      .serial_side_negotiation_enable(serial_side_negotiation_enable),
      .downshift_to_ten_enable(downshift_to_ten_enable),
      .tx_clock_select(tx_clock_select),
      .tx_clock_off(tx_clock_off),
      .collision_in_full_duplex_enable(collision_in_full_duplex_enable),
      .legacy_scrambler_auto_enable(legacy_scrambler_auto_enable),
      .leader_semi_cross_enable(leader_semi_cross_enable),
      .follower_semi_cross_enable(follower_semi_cross_enable)
   );
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task tally_and_finish;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      n_checks++;
      if (s !== x) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, x, s);
      end
   endtask
   // one apb transfer; request held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_fail++;
         tally_and_finish;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task pulse(input logic [11:0] v);
      @(posedge core_clk);
      evt_v <= v;
      @(posedge core_clk);
      evt_v <= 12'h0;
   endtask
   task s_reset;
      apb(0, A_CF, 0); chk("cfg", rd, 32'h29c7);
      apb(0, A_ST, 0); chk("status", rd, 32'h0);
      apb(0, A_RX, 0); chk("count", rd, 32'h0);
      chk("int", int_pin, 1);
   endtask
   // enables are all off here, so capture must not depend on them
   task s_events;
      for (int i = 0; i < 12; i++) begin
         pulse(12'h800 >> i);
         apb(0, A_ST, 0); chk("latch", rd, 32'h1 << POS[i]);
         apb(0, A_ST, 0); chk("cleared", rd, 32'h0);
      end
      @(posedge core_clk);
      ro_v <= 4'hf;
      apb(0, A_ST, 0); chk("live", rd, 32'h020e);
      apb(0, A_ST, 0); chk("live2", rd, 32'h020e);
      ro_v <= 4'h0;
      // an event in the access cycle of a read comes after the sampled word
      fork
         apb(0, A_ST, 0);
         begin
            @(posedge core_clk);
            @(posedge core_clk);
            evt_v <= 12'h001;
            @(posedge core_clk);
            evt_v <= 12'h000;
         end
      join
      chk("late miss", rd, 32'h0);
      apb(0, A_ST, 0); chk("late kept", rd, 32'h1);
   endtask
   task s_int;
      apb(1, pescr_pkg::ADDR_IRQ_ENABLE, 1);
      pulse(12'h001);
      #1 chk("int low", int_pin, 0);
      apb(1, A_CF, 32'h09c7);
      #1 chk("int high", int_pin, 1);
      apb(0, A_ST, 0); chk("jabber", rd, 1);
      #1 chk("int idle", int_pin, 0);
      apb(1, pescr_pkg::ADDR_IRQ_ENABLE, 0);
   endtask
   task s_cfg;
      for (int k = 0; k < 4; k++) begin
         apb(1, A_CF, 32'h21c7 | (k << 10) | (k << 4));
         #1 chk("attempts", downshift_attempts, 1 << k);
         chk("txclk", {tx_clock_off, tx_clock_select}, k | ((k >> 1) << 2));
      end
      apb(1, A_CF, 32'hffffd638);
      #1 chk("soft", serial_soft_reset_pulse, 1);
      chk("pins", {powered_device_detect_enable, serial_tx_error_suppress, 2'h0,
         downshift_attempt_count, downshift_enable, downshift_enhanced_enable,
         serial_side_negotiation_enable, downshift_to_ten_enable, tx_clock_select,
         collision_in_full_duplex_enable, legacy_scrambler_auto_enable,
         leader_semi_cross_enable, follower_semi_cross_enable}, 32'hc638);
      apb(0, A_CF, 0); chk("cfg back", rd, 32'hc638);
      apb(1, A_CF, 32'h29c7);
   endtask
   task s_count(input int n, input logic [31:0] x);
      @(posedge core_clk);
      rx_symbol_error <= 1'b1;
      repeat (n) @(posedge core_clk);
      rx_symbol_error <= 1'b0;
      apb(0, A_RX, 0); chk("count", rd, x);
      apb(1, A_RX, x);
      apb(0, A_RX, 0); chk("w1c", rd, 0);
   endtask
   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata, evt_v, ro_v, rx_symbol_error} = '0;
      rst = 1'b1;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      s_reset;
      s_events;
      s_int;
      s_cfg;
      s_count(5, 32'h5);
      s_count(65540, 32'hffff);
      apb(0, 8'h58, 0); chk("unmapped", {err, rd[30:0]}, 32'h80000000);
      tally_and_finish;
   end
endmodule
bind pescr_regs pescr_regs_assertions u_chk (
   .core_clk(core_clk),
   .rst(rst),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .serial_soft_reset_pulse(serial_soft_reset_pulse),
   .downshift_attempt_count(downshift_attempt_count),
   .downshift_attempts(downshift_attempts),
   .tx_clock_select(tx_clock_select),
   .tx_clock_off(tx_clock_off)
);
